// file: cpwm_buffer_start.v
// Double-buffered count update, start-up shutdown control and pin routing for the PWM generator.
`timescale 1ns/1ps
`include "cpwm_map.vh"
module cpwm_buffer_start #(
  parameter CW = `CPWM_COUNT_W
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rstn,
  // Control bits written by software.
  input wire generatorEnable,
  input wire loadRequestSet,
  input wire shutdownActiveSet,
  input wire shutdownActiveClr,
  input wire autoRestartEnable,
  input wire [`CPWM_CLKSEL_W-1:0] clockSelect,
  input wire deviceSleep,
  input wire [1:0] altPinFunctionCtrl,
  input wire [`CPWM_OVR_W-1:0] overrideLevelA,
  input wire [`CPWM_OVR_W-1:0] overrideLevelB,
  // Count holding registers and their write strobes.
  input wire [CW-1:0] risePhaseCount,
  input wire [CW-1:0] fallPhaseCount,
  input wire [CW-1:0] riseDeadbandCount,
  input wire [CW-1:0] fallDeadbandCount,
  input wire [CW-1:0] riseBlankingCount,
  input wire [CW-1:0] fallBlankingCount,
  input wire [5:0] countWriteStrobe,
  // Event sources and fault pins.
  input wire riseEventPin,
  input wire faultInputPin0,
  input wire faultInputPin1,
  // Raw generator drive from the timing logic.
  input wire genDriveA,
  input wire genDriveB,
  // Status back to software.
  output reg bufferLoadRequest,
  output reg shutdownActive,
  output reg driveRunning,
  output reg fastOscKeepAlive,
  output reg faultInput,
  // Working buffers for the timing logic.
  output reg [CW-1:0] risePhaseBuf,
  output reg [CW-1:0] fallPhaseBuf,
  output reg [CW-1:0] riseDeadbandBuf,
  output reg [CW-1:0] fallDeadbandBuf,
  output reg [CW-1:0] riseBlankingBuf,
  output reg [CW-1:0] fallBlankingBuf,
  // Routed output pins, level and enable.
  output reg genOutputA0,
  output reg genOutputA0En,
  output reg genOutputA1,
  output reg genOutputA1En,
  output reg genOutputB0,
  output reg genOutputB0En,
  output reg genOutputB1,
  output reg genOutputB1En
);

  wire [2:0] syncOut;
  wire riseEvent;
  wire fault0;
  wire fault1;
  reg riseLastReg;
  wire riseEdge;
  reg pendingStartReg;
  reg [`CPWM_OVR_W-1:0] levelA;
  reg [`CPWM_OVR_W-1:0] levelB;
  reg [1:0] pinA;
  reg [1:0] pinB;

  // ----------------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------------
  // Event sources may be asynchronous, so they pass the filtered chain first.
  cpwm_sync #(
    .WIDTH(3)
  ) uSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .dIn({faultInputPin1, faultInputPin0, riseEventPin}),
    .dOut(syncOut)
  );
  // The filter adds three to four cycles of latency, so a load or a start lands four to five cycles
  // after the pin rises; the delay buys immunity to a runt pulse on the pin.
  assign riseEvent = syncOut[`CPWM_LANE_RISE];
  assign fault0 = syncOut[`CPWM_LANE_FLT0];
  assign fault1 = syncOut[`CPWM_LANE_FLT1];
  assign riseEdge = riseEvent & ~riseLastReg;

  // Resolve an override code to a pin level and enable.
  function [1:0] resolvePin;
    input [`CPWM_OVR_W-1:0] code;
    input run;
    input drive;
    begin
      if (run) begin
        resolvePin = {1'b1, drive};
      end else begin
        case (code)
          `CPWM_OVR_LOW: resolvePin = 2'h2;
          `CPWM_OVR_HIGH: resolvePin = 2'h3;
          `CPWM_OVR_HIZ: resolvePin = 2'h0;
          default: resolvePin = {1'b1, drive};
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Working buffers and load request
  // ----------------------------------------------------------------------------
  // A disabled generator takes each written count at once; an enabled one waits for the
  // request and the next rising event, so a period never mixes old and new counts.
  // Disabling drops a pending request, because the disabled writes already reach the
  // buffers directly and a stale request would reload them at the first rising event.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      riseLastReg <= 1'b0;
      bufferLoadRequest <= 1'b0;
      risePhaseBuf <= `CPWM_COUNT_RST;
      fallPhaseBuf <= `CPWM_COUNT_RST;
      riseDeadbandBuf <= `CPWM_COUNT_RST;
      fallDeadbandBuf <= `CPWM_COUNT_RST;
      riseBlankingBuf <= `CPWM_COUNT_RST;
      fallBlankingBuf <= `CPWM_COUNT_RST;
    end else begin
      riseLastReg <= riseEvent;
      if (!generatorEnable) begin
        if (countWriteStrobe[`CPWM_STB_RPH]) risePhaseBuf <= risePhaseCount;
        if (countWriteStrobe[`CPWM_STB_FPH]) fallPhaseBuf <= fallPhaseCount;
        if (countWriteStrobe[`CPWM_STB_RDB]) riseDeadbandBuf <= riseDeadbandCount;
        if (countWriteStrobe[`CPWM_STB_FDB]) fallDeadbandBuf <= fallDeadbandCount;
        if (countWriteStrobe[`CPWM_STB_RBK]) riseBlankingBuf <= riseBlankingCount;
        if (countWriteStrobe[`CPWM_STB_FBK]) fallBlankingBuf <= fallBlankingCount;
        bufferLoadRequest <= 1'b0;
      end else if (bufferLoadRequest && riseEdge) begin
        risePhaseBuf <= risePhaseCount;
        fallPhaseBuf <= fallPhaseCount;
        riseDeadbandBuf <= riseDeadbandCount;
        fallDeadbandBuf <= fallDeadbandCount;
        riseBlankingBuf <= riseBlankingCount;
        fallBlankingBuf <= fallBlankingCount;
        bufferLoadRequest <= loadRequestSet;
      end else if (loadRequestSet) begin
        bufferLoadRequest <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Shutdown and start sequence
  // ----------------------------------------------------------------------------
  // Drive starts only on a rising event after shutdown is released; a software set wins
  // over any clear, so the outputs never leave their override levels by accident.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shutdownActive <= `CPWM_SD_RST;
      pendingStartReg <= 1'b0;
      driveRunning <= 1'b0;
      fastOscKeepAlive <= 1'b0;
      faultInput <= 1'b0;
    end else begin
      faultInput <= altPinFunctionCtrl[`CPWM_APF_FLT] ? fault1 : fault0;
      // The keep-alive stands whether or not the device sleeps, so it is already up
      // when sleep begins and the oscillator never misses a cycle at sleep entry.
      fastOscKeepAlive <= generatorEnable &&
        (clockSelect == `CPWM_CLKSEL_FASTOSC);
      if (shutdownActiveSet) begin
        shutdownActive <= 1'b1;
      end else if (autoRestartEnable && shutdownActive) begin
        shutdownActive <= 1'b0;
      end else if (shutdownActiveClr) begin
        shutdownActive <= 1'b0;
      end
      if (!generatorEnable || shutdownActive) begin
        driveRunning <= 1'b0;
        pendingStartReg <= 1'b1;
      end else if (pendingStartReg && riseEdge) begin
        driveRunning <= 1'b1;
        pendingStartReg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------------------
  // Sleep is not looked at: the block keeps running while its clock and events do.
  always @* begin
    levelA = driveRunning ? `CPWM_OVR_RUN : overrideLevelA;
    levelB = driveRunning ? `CPWM_OVR_RUN : overrideLevelB;
    pinA = generatorEnable ? resolvePin(levelA, driveRunning, genDriveA) : 2'h0;
    pinB = generatorEnable ? resolvePin(levelB, driveRunning, genDriveB) : 2'h0;
  end

  // Registered pins keep every output straight from a flip-flop.
  // Only one pin of each pair is ever enabled; the alternate pins are weaker drivers, so
  // a user must check the load before routing outputs there.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      genOutputA0 <= 1'b0;
      genOutputA0En <= 1'b0;
      genOutputA1 <= 1'b0;
      genOutputA1En <= 1'b0;
      genOutputB0 <= 1'b0;
      genOutputB0En <= 1'b0;
      genOutputB1 <= 1'b0;
      genOutputB1En <= 1'b0;
    end else begin
      genOutputA0 <= pinA[0];
      genOutputA0En <= pinA[1] & ~altPinFunctionCtrl[`CPWM_APF_OUT];
      genOutputA1 <= pinA[0];
      genOutputA1En <= pinA[1] & altPinFunctionCtrl[`CPWM_APF_OUT];
      genOutputB0 <= pinB[0];
      genOutputB0En <= pinB[1] & ~altPinFunctionCtrl[`CPWM_APF_OUT];
      genOutputB1 <= pinB[0];
      genOutputB1En <= pinB[1] & altPinFunctionCtrl[`CPWM_APF_OUT];
    end
  end

endmodule // cpwm_buffer_start

// file: cpwm_buffer_start_properties.sv
// Port checker for the PWM buffer and start block.
`timescale 1ns/1ps
`include "cpwm_map.vh"
module cpwm_bs_props #(parameter CW = `CPWM_COUNT_W) (
  // Clock, reset and controls.
  input wire clk_sys,
  input wire rstn,
  input wire generatorEnable,
  input wire loadRequestSet,
  input wire shutdownActiveSet,
  input wire autoRestartEnable,
  input wire [`CPWM_CLKSEL_W-1:0] clockSelect,
  input wire [1:0] altPinFunctionCtrl,
  input wire [CW-1:0] risePhaseCount,
  input wire [CW-1:0] fallBlankingCount,
  input wire [5:0] countWriteStrobe,
  // Status, buffers and pins.
  input wire bufferLoadRequest,
  input wire shutdownActive,
  input wire driveRunning,
  input wire fastOscKeepAlive,
  input wire [CW-1:0] risePhaseBuf,
  input wire [CW-1:0] fallBlankingBuf,
  input wire genOutputA0En,
  input wire genOutputB0En
);
  // Pending requests must clear within two and a half event periods.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_dis_write: assert property (!generatorEnable && countWriteStrobe[0]
    |=> risePhaseBuf == $past(risePhaseCount)) else $error("write missed");
  a_en_hold: assert property (generatorEnable && !bufferLoadRequest
    |=> $stable(fallBlankingBuf)) else $error("buffer moved");
  a_load_copy: assert property ($fell(bufferLoadRequest) && $past(generatorEnable)
    |-> fallBlankingBuf == $past(fallBlankingCount)) else $error("load lost");
  a_load_done: assert property ($rose(bufferLoadRequest) && generatorEnable
    |-> ##[1:40] !bufferLoadRequest) else $error("load hung");
  a_req_set: assert property (loadRequestSet && generatorEnable && !bufferLoadRequest
    |=> bufferLoadRequest) else $error("request lost");
  a_auto_restart: assert property (autoRestartEnable && shutdownActive
    && !shutdownActiveSet |=> !shutdownActive) else $error("no restart");
  a_start_gate: assert property ($rose(driveRunning)
    |-> !$past(shutdownActive)) else $error("early drive");
  a_fast_osc: assert property (generatorEnable
    && clockSelect == `CPWM_CLKSEL_FASTOSC |=> fastOscKeepAlive) else $error("osc off");
  a_osc_off: assert property (!generatorEnable
    |=> !fastOscKeepAlive) else $error("osc held");
  a_alt_route: assert property (altPinFunctionCtrl[0] && $past(altPinFunctionCtrl[0])
    |-> !genOutputA0En && !genOutputB0En) else $error("bad route");
  c_load: cover property ($fell(bufferLoadRequest));
  c_run: cover property ($rose(driveRunning));
  c_restart: cover property ($fell(shutdownActive) && autoRestartEnable);
endmodule // cpwm_bs_props
bind cpwm_buffer_start cpwm_bs_props #(.CW(CW)) u_props (.clk_sys(clk_sys), .rstn(rstn),
  .generatorEnable(generatorEnable), .loadRequestSet(loadRequestSet),
  .shutdownActiveSet(shutdownActiveSet), .autoRestartEnable(autoRestartEnable),
  .clockSelect(clockSelect), .altPinFunctionCtrl(altPinFunctionCtrl),
  .risePhaseCount(risePhaseCount), .fallBlankingCount(fallBlankingCount),
  .countWriteStrobe(countWriteStrobe), .bufferLoadRequest(bufferLoadRequest),
  .shutdownActive(shutdownActive), .driveRunning(driveRunning),
  .fastOscKeepAlive(fastOscKeepAlive), .risePhaseBuf(risePhaseBuf),
  .fallBlankingBuf(fallBlankingBuf), .genOutputA0En(genOutputA0En),
  .genOutputB0En(genOutputB0En));

// file: cpwm_map.vh
// Constants, field layouts and reset values for the complementary PWM buffer and start block.
//
// Behaviour
// - Disabled: count writes load working buffers at once.
// - Enabled: count writes wait for load request.
// - Load request copies all six counts together.
// - Hardware clears load request after transfer.
// - Each count has its own working buffer.
// - Generator runs on in sleep with sources.
// - Fast oscillator kept alive in sleep when used.
// - Outputs and fault routable to alternate pins.
// - Auto-restart set clears shutdown-active automatically.
// - Shutdown-active clear starts drive at rising event.
`ifndef CPWM_MAP_VH
`define CPWM_MAP_VH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define CPWM_COUNT_W 6
`define CPWM_COUNT_RST 6'h00
`define CPWM_CLKSEL_W 2
`define CPWM_CLKSEL_FASTOSC 2'h2

// ----------------------------------------------------------------------------
// Override level encodings
// ----------------------------------------------------------------------------
`define CPWM_OVR_W 2
`define CPWM_OVR_LOW 2'h0
`define CPWM_OVR_HIGH 2'h1
`define CPWM_OVR_HIZ 2'h2
`define CPWM_OVR_RUN 2'h3

// ----------------------------------------------------------------------------
// Bit positions of strobes, pin function controls and synchroniser lanes
// ----------------------------------------------------------------------------
`define CPWM_STB_RPH 0
`define CPWM_STB_FPH 1
`define CPWM_STB_RDB 2
`define CPWM_STB_FDB 3
`define CPWM_STB_RBK 4
`define CPWM_STB_FBK 5
`define CPWM_APF_OUT 0
`define CPWM_APF_FLT 1
`define CPWM_LANE_RISE 0
`define CPWM_LANE_FLT0 1
`define CPWM_LANE_FLT1 2
`define CPWM_SD_RST 1'b1

`endif

// file: cpwm_partner.sv
// Event source and switch driver model facing the PWM block.
`timescale 1ns/1ps
module cpwm_partner (
  // Clock and run control.
  input wire clk_sys,
  input wire run,
  // Event and drive lines.
  output wire riseEventPin,
  output wire genDriveA,
  output wire genDriveB
);
  logic [3:0] ph = 4'h0;
  // Sources keep running in sleep, so the generator can run on; period 16.
  always @(posedge clk_sys) ph <= ph + 4'h1;
  assign riseEventPin = run && !ph[3];
  assign genDriveA = !ph[3];
  assign genDriveB = ph[3];
endmodule // cpwm_partner

// file: cpwm_sync.v
// Three-stage input synchroniser with agreement filter for outside signals.
`timescale 1ns/1ps
module cpwm_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rstn,
  // Raw and clean signal.
  input wire [WIDTH-1:0] dIn,
  output reg [WIDTH-1:0] dOut
);

  reg [WIDTH-1:0] stage1Reg;
  reg [WIDTH-1:0] stage2Reg;
  reg [WIDTH-1:0] stage3Reg;
  integer i;

  // ----------------------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------------------
  // Only the second stage reads the first; the output moves once stages two and three agree.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1Reg <= {WIDTH{1'b0}};
      stage2Reg <= {WIDTH{1'b0}};
      stage3Reg <= {WIDTH{1'b0}};
      dOut <= {WIDTH{1'b0}};
    end else begin
      stage1Reg <= dIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2Reg[i] == stage3Reg[i]) begin
          dOut[i] <= stage3Reg[i];
        end
      end
    end
  end

endmodule // cpwm_sync

// file: tb.sv
// Self-checking bench for the PWM buffer and start block.
`timescale 1ns/1ps
`include "cpwm_map.vh"
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic generatorEnable, loadRequestSet, shutdownActiveSet, shutdownActiveClr;
  logic autoRestartEnable, deviceSleep, faultInputPin0, faultInputPin1;
  logic [1:0] clockSelect, altPinFunctionCtrl, overrideLevelA, overrideLevelB;
  logic [5:0] risePhaseCount, fallPhaseCount, riseDeadbandCount, fallDeadbandCount;
  logic [5:0] riseBlankingCount, fallBlankingCount, countWriteStrobe;
  wire riseEventPin, genDriveA, genDriveB, bufferLoadRequest, shutdownActive, driveRunning;
  wire fastOscKeepAlive, faultInput, genOutputA0, genOutputA0En, genOutputA1, genOutputA1En;
  wire genOutputB0, genOutputB0En, genOutputB1, genOutputB1En;
  wire [5:0] risePhaseBuf, fallPhaseBuf, riseDeadbandBuf, fallDeadbandBuf;
  wire [5:0] riseBlankingBuf, fallBlankingBuf;
  wire [35:0] bufs = {risePhaseBuf, fallPhaseBuf, riseDeadbandBuf, fallDeadbandBuf,
    riseBlankingBuf, fallBlankingBuf};
  logic [35:0] model, v;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  cpwm_buffer_start dut (
    .clk_sys(clk_sys), .rstn(rstn), .generatorEnable(generatorEnable),
    .loadRequestSet(loadRequestSet), .shutdownActiveSet(shutdownActiveSet),
    .shutdownActiveClr(shutdownActiveClr), .autoRestartEnable(autoRestartEnable),
    .clockSelect(clockSelect), .deviceSleep(deviceSleep),
    .altPinFunctionCtrl(altPinFunctionCtrl),
    .overrideLevelA(overrideLevelA), .overrideLevelB(overrideLevelB),
    .risePhaseCount(risePhaseCount), .fallPhaseCount(fallPhaseCount),
    .riseDeadbandCount(riseDeadbandCount), .fallDeadbandCount(fallDeadbandCount),
    .riseBlankingCount(riseBlankingCount), .fallBlankingCount(fallBlankingCount),
    .countWriteStrobe(countWriteStrobe), .riseEventPin(riseEventPin),
    .faultInputPin0(faultInputPin0), .faultInputPin1(faultInputPin1),
    .genDriveA(genDriveA), .genDriveB(genDriveB), .bufferLoadRequest(bufferLoadRequest),
    .shutdownActive(shutdownActive), .driveRunning(driveRunning),
    .fastOscKeepAlive(fastOscKeepAlive), .faultInput(faultInput),
    .risePhaseBuf(risePhaseBuf), .fallPhaseBuf(fallPhaseBuf),
    .riseDeadbandBuf(riseDeadbandBuf), .fallDeadbandBuf(fallDeadbandBuf),
    .riseBlankingBuf(riseBlankingBuf), .fallBlankingBuf(fallBlankingBuf),
    .genOutputA0(genOutputA0), .genOutputA0En(genOutputA0En),
    .genOutputA1(genOutputA1), .genOutputA1En(genOutputA1En),
    .genOutputB0(genOutputB0), .genOutputB0En(genOutputB0En),
    .genOutputB1(genOutputB1), .genOutputB1En(genOutputB1En));
  cpwm_partner u_far (.clk_sys(clk_sys), .run(1'b1), .riseEventPin(riseEventPin),
    .genDriveA(genDriveA), .genDriveB(genDriveB));
  // Clock at 200 MHz.
  always #2.5 clk_sys = ~clk_sys;
  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      print_verdict();
    end
  end
  // A write lands in its field at once only while the generator is off.
  function automatic logic [35:0] predict(input logic [35:0] old, val, input int i, input logic en);
    if (!en) old[6*(5-i)+:6] = val[6*(5-i)+:6];
    return old;
  endfunction
  task automatic check(input string nm, input logic [35:0] seen, want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wr(input logic [35:0] val, input logic [5:0] stb);
    @(negedge clk_sys);
    {risePhaseCount, fallPhaseCount, riseDeadbandCount, fallDeadbandCount,
      riseBlankingCount, fallBlankingCount} = val;
    countWriteStrobe = stb;
    @(negedge clk_sys);
    countWriteStrobe = 6'h00;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence, inputs change on falling edges.
  initial begin
    {generatorEnable, loadRequestSet, shutdownActiveSet, shutdownActiveClr} = 4'h0;
    {autoRestartEnable, deviceSleep, faultInputPin0, faultInputPin1} = 4'h0;
    {clockSelect, altPinFunctionCtrl, countWriteStrobe} = 10'h000;
    {risePhaseCount, fallPhaseCount, riseDeadbandCount} = 18'h00000;
    {fallDeadbandCount, riseBlankingCount, fallBlankingCount} = 18'h00000;
    overrideLevelA = `CPWM_OVR_LOW;
    overrideLevelB = `CPWM_OVR_HIGH;
    model = 36'h0;
    void'($urandom(52));
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    check("sd", shutdownActive, 1);
    check("pins", {genOutputA0En, genOutputA1En, genOutputB0En, genOutputB1En}, 4'h0);
    for (int i = 0; i < 6; i++) begin
      v = (i == 5) ? 36'hF_FFFF_FFFF : {4'($urandom()), $urandom()};
      wr(v, 6'(1 << i));
      model = predict(model, v, i, generatorEnable);
      check("wr", bufs, model);
    end
    shutdownActiveSet = 1'b1;
    clockSelect = `CPWM_CLKSEL_FASTOSC;
    @(negedge clk_sys);
    shutdownActiveSet = 1'b0;
    generatorEnable = 1'b1;
    deviceSleep = 1'b1;
    @(negedge clk_sys);
    check("osc", fastOscKeepAlive, 1);
    // Pins now turn to outputs and must show the override levels of the shutdown state.
    check("ovr", {genOutputA0En, genOutputA0, genOutputB0En, genOutputB0,
      genOutputA1En, genOutputB1En}, 6'h2C);
    v = {4'($urandom()), $urandom()};
    wr(v, 6'h3F);
    repeat (20) @(negedge clk_sys);
    check("held", bufs, model);
    loadRequestSet = 1'b1;
    @(negedge clk_sys);
    loadRequestSet = 1'b0;
    check("req", bufferLoadRequest, 1);
    for (k = 0; k < 60 && bufferLoadRequest === 1'b1; k++) @(negedge clk_sys);
    check("req", bufferLoadRequest, 0);
    check("load", bufs, v);
    shutdownActiveClr = 1'b1;
    @(negedge clk_sys);
    shutdownActiveClr = 1'b0;
    for (k = 0; k < 40 && driveRunning !== 1'b1; k++) @(negedge clk_sys);
    check("run", {shutdownActive, driveRunning}, 2'b01);
    altPinFunctionCtrl = 2'h3;
    faultInputPin1 = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("alt", {genOutputA0En, genOutputB0En, faultInput, genOutputA1En, genOutputB1En,
      genOutputA1 ^ genOutputB1}, 6'h0F);
    shutdownActiveSet = 1'b1;
    @(negedge clk_sys);
    shutdownActiveSet = 1'b0;
    autoRestartEnable = 1'b1;
    check("sd", shutdownActive, 1);
    repeat (2) @(negedge clk_sys);
    check("auto", shutdownActive, 0);
    // Shut down again with the two remaining override codes and another clock source.
    autoRestartEnable = 1'b0;
    clockSelect = 2'h0;
    overrideLevelA = `CPWM_OVR_HIZ;
    overrideLevelB = `CPWM_OVR_RUN;
    shutdownActiveSet = 1'b1;
    @(negedge clk_sys);
    shutdownActiveSet = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("osc", fastOscKeepAlive, 0);
    check("ovr", {shutdownActive, driveRunning, genOutputA1En, genOutputB1En}, 4'h9);
    print_verdict();
  end
endmodule // tb
